/* shared/sctag_pkg.sv */
// Shared constants and types for the synchronous cache tag compare memory
package sctag_pkg;
  // Geometry of the tag store
  localparam int SCTAG_ENTRIES = 8192;
  localparam int SCTAG_INDEX_W = 13;
  localparam int SCTAG_TAG_W = 15;
  // Invalidate must be seen on this many consecutive rising edges
  localparam int SCTAG_FLUSH_EDGES = 4;
  localparam logic [2:0] SCTAG_FLUSH_CNT_ZERO = 3'h0;
  localparam logic [2:0] SCTAG_FLUSH_CNT_ONE = 3'h1;
  // Clock of the surrounding logic
  localparam int SCTAG_CLK_MHZ = 50;

  // Operation decoded from the registered controls
  typedef enum logic [2:0] {
    SCTAG_OP_IDLE,
    SCTAG_OP_COMPARE,
    SCTAG_OP_READ,
    SCTAG_OP_WRITE,
    SCTAG_OP_FLUSH
  } sctag_op_e;

  // Flush sequencer states
  typedef enum logic [1:0] {
    SCTAG_FL_IDLE,
    SCTAG_FL_COUNT,
    SCTAG_FL_SWEEP
  } sctag_fl_e;
endpackage : sctag_pkg

/* hw/sctag_mem.sv */
// Single-port tag storage with registered read data
`timescale 1ns/100ps
module sctag_mem
  import sctag_pkg::*;
#(
  parameter int DEPTH = SCTAG_ENTRIES,
  parameter int AW = SCTAG_INDEX_W,
  parameter int DW = SCTAG_TAG_W
) (
  input wire logic clk,
  input wire logic writeEn,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] writeData,
  output logic [DW-1:0] readData
);
  initial begin
    if (DEPTH > (1 << AW)) begin
      $error("sctag_mem: depth exceeds address range");
    end
  end

  logic [DW-1:0] store [DEPTH];

  // Read-before-write; no reset so the array can map to block RAM
  always_ff @(posedge clk) begin
    if (writeEn) begin
      store[addr] <= writeData;
    end
    readData <= store[addr];
  end
endmodule // sctag_mem

/* hw/sctag_valid.sv */
// Valid-bit array with whole-array flush
`timescale 1ns/100ps
module sctag_valid
  import sctag_pkg::*;
#(
  parameter int DEPTH = SCTAG_ENTRIES,
  parameter int AW = SCTAG_INDEX_W
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clearAll,
  input wire logic writeEn,
  input wire logic [AW-1:0] addr,
  input wire logic writeBit,
  output logic readBit
);
  initial begin
    if (DEPTH > (1 << AW)) begin
      $error("sctag_valid: depth exceeds address range");
    end
  end

  // Flip-flops, not RAM: a flush must clear every bit in one edge
  logic [DEPTH-1:0] bits;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bits <= '0;
      readBit <= 1'b0;
    end else begin
      if (clearAll) begin
        bits <= '0;
      end else if (writeEn) begin
        bits[addr] <= writeBit;
      end
      readBit <= bits[addr];
    end
  end
endmodule // sctag_valid

/* hw/sctag_top.sv */
// Synchronous cache tag compare memory, device side
`timescale 1ns/100ps
module sctag_top
  import sctag_pkg::*;
#(
  parameter int ENTRIES = SCTAG_ENTRIES,
  parameter int INDEX_W = SCTAG_INDEX_W,
  parameter int TAG_W = SCTAG_TAG_W
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [INDEX_W-1:0] entry_index,
  input wire logic access_sel_n,
  input wire logic tag_store_n,
  input wire logic flush_all_n,
  input wire logic sel_low_a_n,
  input wire logic sel_high_b,
  input wire logic sel_low_c_n,
  input wire logic drive_enable_n,
  input wire logic [TAG_W-1:0] tagBusIn,
  output logic [TAG_W-1:0] tagBusOut,
  output logic tagBusOe,
  input wire logic entryLiveIn,
  output logic entryLiveOut,
  output logic entryLiveOe,
  output logic tag_hit,
  output logic tagHitOe
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks

  initial begin
    if (ENTRIES != (1 << INDEX_W)) begin
      $error("sctag_top: entries must equal two to the index width");
    end
    if (TAG_W < 1) begin
      $error("sctag_top: tag width must be positive");
    end
    // The flush counter is three bits wide and must reach its last count
    if (SCTAG_FLUSH_EDGES < 2 || SCTAG_FLUSH_EDGES > 7) begin
      $error("sctag_top: flush edge count does not fit its counter");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoding used by the request decode

  // Chip is selected only for the one polarity combination
  function automatic logic isSelected(input logic aN, input logic b, input logic cN);
    return !aN && b && !cN;
  endfunction

  // Pick the operation from registered controls; flush dominates
  function automatic sctag_op_e decodeOp(input logic flushN, input logic sel,
                                         input logic accN, input logic storeN);
    if (!flushN) begin
      return SCTAG_OP_FLUSH;
    end else if (!sel) begin
      return SCTAG_OP_IDLE;
    end else if (accN) begin
      return SCTAG_OP_COMPARE;
    end else if (!storeN) begin
      return SCTAG_OP_WRITE;
    end else begin
      return SCTAG_OP_READ;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    // Two-stage synchronisers for every pin sampled on the clock
    logic [INDEX_W-1:0] idxMeta;
    logic [INDEX_W-1:0] idxSync;
    logic [TAG_W-1:0] tagMeta;
    logic [TAG_W-1:0] tagSync;
    logic [5:0] ctlMeta;
    logic [5:0] ctlSync;
    logic liveMeta;
    logic liveSync;
    logic [1:0] oeMeta;
    logic [1:0] oeSync;
    // Captured request, compared against memory output one edge later
    sctag_op_e op;
    logic [TAG_W-1:0] cmpTag;
    // Flush tracking
    sctag_fl_e flState;
    logic [2:0] flCount;
    // Output registers
    logic [TAG_W-1:0] tagOut;
    logic tagOe;
    logic liveOut;
    logic liveOe;
    logic hit;
    logic hitOe;
  } sctag_state_s;

  sctag_state_s state_reg;
  sctag_state_s state_next;

  logic [TAG_W-1:0] memTag;
  logic memValid;
  logic memWrite;
  logic validWrite;
  logic flushClear;
  logic [INDEX_W-1:0] memAddr;
  sctag_op_e reqOp;

  // Control bit positions inside the control synchroniser
  localparam int CTL_ACC = 0;
  localparam int CTL_STORE = 1;
  localparam int CTL_FLUSH = 2;
  localparam int CTL_SA = 3;
  localparam int CTL_SB = 4;
  localparam int CTL_SC = 5;
  localparam int OE_DQ = 0;
  localparam int OE_DIR = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Request decode from synchronised pins

  // select re-evaluated every edge
  // Flush decodes ahead of select, so invalidation runs deselected
  always_comb begin
    reqOp = decodeOp(state_reg.ctlSync[CTL_FLUSH],
                     isSelected(state_reg.ctlSync[CTL_SA], state_reg.ctlSync[CTL_SB],
                                state_reg.ctlSync[CTL_SC]),
                     state_reg.ctlSync[CTL_ACC], state_reg.ctlSync[CTL_STORE]);
  end

  assign memAddr = state_reg.idxSync;
  assign memWrite = (reqOp == SCTAG_OP_WRITE);
  // valid pin value stored on write
  assign validWrite = memWrite;
  assign flushClear = (reqOp == SCTAG_OP_FLUSH) && (state_reg.flCount == 3'(SCTAG_FLUSH_EDGES - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  // Tag RAM has no reset: only the valid bits need a known state
  // tag array
  sctag_mem #(
    .DEPTH(ENTRIES),
    .AW(INDEX_W),
    .DW(TAG_W)
  ) u_tags (
    .clk(clk),
    .writeEn(memWrite),
    .addr(memAddr),
    .writeData(state_reg.tagSync),
    .readData(memTag)
  );

  sctag_valid #(
    .DEPTH(ENTRIES),
    .AW(INDEX_W)
  ) u_valid (
    .clk(clk),
    .reset_n(reset_n),
    .clearAll(flushClear),
    .writeEn(validWrite),
    .addr(memAddr),
    .writeBit(state_reg.liveSync),
    .readBit(memValid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    state_next = state_reg;
    // Synchronisers: first stage read only by second stage
    state_next.idxMeta = entry_index;
    state_next.idxSync = state_reg.idxMeta;
    state_next.tagMeta = tagBusIn;
    state_next.tagSync = state_reg.tagMeta;
    state_next.ctlMeta = {sel_low_c_n, sel_high_b, sel_low_a_n, flush_all_n, tag_store_n, access_sel_n};
    state_next.ctlSync = state_reg.ctlMeta;
    state_next.liveMeta = entryLiveIn;
    state_next.liveSync = state_reg.liveMeta;
    // Drive enable is asynchronous at the pin; synchronised here only to
    // keep one clock, costing two cycles of enable latency
    state_next.oeMeta = {drive_enable_n, drive_enable_n};
    state_next.oeSync = state_reg.oeMeta;

    state_next.op = reqOp;
    state_next.cmpTag = state_reg.tagSync;

    unique case (state_reg.flState)
      SCTAG_FL_IDLE: begin
        if (reqOp == SCTAG_OP_FLUSH) begin
          state_next.flState = SCTAG_FL_COUNT;
          state_next.flCount = SCTAG_FLUSH_CNT_ONE;
        end
      end
      SCTAG_FL_COUNT: begin
        // A release before the last edge aborts and rearms the count
        if (reqOp != SCTAG_OP_FLUSH) begin
          state_next.flState = SCTAG_FL_IDLE;
          state_next.flCount = SCTAG_FLUSH_CNT_ZERO;
        end else if (flushClear) begin
          state_next.flState = SCTAG_FL_SWEEP;
        end else begin
          state_next.flCount = state_reg.flCount + SCTAG_FLUSH_CNT_ONE;
        end
      end
      SCTAG_FL_SWEEP: begin
        // Stay here while flush is held; release rearms the counter
        if (reqOp != SCTAG_OP_FLUSH) begin
          state_next.flState = SCTAG_FL_IDLE;
          state_next.flCount = SCTAG_FLUSH_CNT_ZERO;
        end
      end
    endcase

    // Outputs, one edge after the memory read returns
    // Op and compare tag were registered with the read, so they line up with it
    unique case (state_reg.op)
      SCTAG_OP_IDLE: begin
        // deselected floats everything
        // Tag register keeps the last read value
        state_next.tagOe = 1'b0;
        state_next.liveOe = 1'b0;
        state_next.hitOe = 1'b0;
        state_next.hit = 1'b0;
        state_next.liveOut = 1'b0;
      end
      SCTAG_OP_COMPARE: begin
        state_next.hit = memValid && (memTag == state_reg.cmpTag);
        state_next.hitOe = 1'b1;
        state_next.liveOut = memValid;
        // Forbidden enable-low compare: bus stays an input, valid pin follows enable
        // tag bus is an input here
        state_next.tagOe = 1'b0;
        state_next.liveOe = !state_reg.oeSync[OE_DIR];
      end
      SCTAG_OP_READ: begin
        // hit held high in access mode
        state_next.hit = 1'b1;
        state_next.hitOe = 1'b1;
        state_next.tagOut = memTag;
        state_next.liveOut = memValid;
        // Enable lags the op by one edge less than the data path
        // drive only with enable low
        state_next.tagOe = !state_reg.oeSync[OE_DQ];
        state_next.liveOe = !state_reg.oeSync[OE_DIR];
      end
      SCTAG_OP_WRITE: begin
        // no tag or valid drive on a write
        // Write data came from the synchronised pins; only the hit pin is driven back, high
        state_next.hit = 1'b1;
        state_next.hitOe = 1'b1;
        state_next.tagOe = 1'b0;
        state_next.liveOe = 1'b0;
      end
      SCTAG_OP_FLUSH: begin
        // hit drive ignores output enable
        // Tag bus keeps stale read data; the far side treats it as unknown
        state_next.hit = 1'b0;
        state_next.hitOe = 1'b1;
        state_next.liveOut = 1'b0;
        state_next.liveOe = !state_reg.oeSync[OE_DIR];
        state_next.tagOe = !state_reg.oeSync[OE_DQ];
      end
      default: begin
        // Unused op codes float every pin
        state_next.hitOe = 1'b0;
        state_next.tagOe = 1'b0;
        state_next.liveOe = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Reset is a simulation convenience; the real part relies on flush
  // Synchroniser stages reset to idle pin levels: deselected, no flush
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '{
        idxMeta: '0, idxSync: '0, tagMeta: '0, tagSync: '0,
        ctlMeta: 6'h3F, ctlSync: 6'h3F, liveMeta: 1'b0, liveSync: 1'b0,
        oeMeta: 2'h3, oeSync: 2'h3, op: SCTAG_OP_IDLE, cmpTag: '0,
        flState: SCTAG_FL_IDLE, flCount: SCTAG_FLUSH_CNT_ZERO,
        tagOut: '0, tagOe: 1'b0, liveOut: 1'b0, liveOe: 1'b0,
        hit: 1'b0, hitOe: 1'b0
      };
    end else begin
      state_reg <= state_next;
    end
  end

  // Output pins straight from the state flip-flops
  // No input reaches a pin without passing at least three flip-flops
  assign tagBusOut = state_reg.tagOut;
  assign tagBusOe = state_reg.tagOe;
  assign entryLiveOut = state_reg.liveOut;
  assign entryLiveOe = state_reg.liveOe;
  assign tag_hit = state_reg.hit;
  assign tagHitOe = state_reg.hitOe;
endmodule // sctag_top

/* verification/sctag_asserts.sv */
// Pin-level checks for the cache tag compare memory
`timescale 1ns/100ps
module sctag_asserts
  import sctag_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic access_sel_n,
  input wire logic tag_store_n,
  input wire logic flush_all_n,
  input wire logic sel_low_a_n,
  input wire logic sel_high_b,
  input wire logic sel_low_c_n,
  input wire logic drive_enable_n,
  input wire logic tagBusOe,
  input wire logic entryLiveOut,
  input wire logic entryLiveOe,
  input wire logic tag_hit,
  input wire logic tagHitOe
);
  logic [3:0] ageReg;
  logic selNow;
  logic up;
  ////////////////////////////////////////
  // Age since reset, so deep history never reaches into reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ageReg <= 4'h0;
    end else if (ageReg != 4'hF) begin
      ageReg <= ageReg + 4'h1;
    end
  end
  assign selNow = !sel_low_a_n && sel_high_b && !sel_low_c_n;
  assign up = ageReg == 4'hF;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  // Outputs land four samples after the pins that caused them
  a_flush_forces_low: assert property (!flush_all_n |-> ##4 (!tag_hit && tagHitOe && !entryLiveOut))
    else $error("flush outputs wrong");
  a_desel_floats: assert property (flush_all_n && !selNow |-> ##4 (!tagHitOe && !tagBusOe && !entryLiveOe))
    else $error("deselected pins driven");
  a_access_hit_high: assert property (up && $past(flush_all_n, 4) && $past(selNow, 4)
    && !$past(access_sel_n, 4) |-> tag_hit && tagHitOe)
    else $error("access hit not high");
  a_compare_no_bus: assert property (flush_all_n && selNow && access_sel_n |-> ##4 (tagHitOe && !tagBusOe))
    else $error("compare pins wrong");
  a_write_no_drive: assert property (up && $past(flush_all_n, 4) && $past(selNow, 4) && !$past(access_sel_n, 4)
    && !$past(tag_store_n, 4) |-> !tagBusOe && !entryLiveOe)
    else $error("write drives pins");
  a_hit_needs_valid: assert property (flush_all_n && selNow && access_sel_n |-> ##4 (!tag_hit || entryLiveOut))
    else $error("hit on invalid entry");
  // Enable passes one stage fewer than the op, so it is taken one sample later
  a_read_drives_bus: assert property (up && $past(flush_all_n, 4) && $past(selNow, 4) && !$past(access_sel_n, 4)
    && $past(tag_store_n, 4) && !$past(drive_enable_n, 3) |-> tagBusOe && entryLiveOe)
    else $error("read pins not driven");
  // Enable lag is hidden by a six-deep window
  a_oe_off_floats: assert property (drive_enable_n [*6] |-> !tagBusOe && !entryLiveOe)
    else $error("pins driven while disabled");
  a_flush_clears: assert property (up && $past(flush_all_n, 4) && $past(selNow, 4) && $past(access_sel_n, 4)
    && !$past(flush_all_n, 5) && !$past(flush_all_n, 6) && !$past(flush_all_n, 7)
    && !$past(flush_all_n, 8) |-> !tag_hit)
    else $error("hit after full flush");
endmodule // sctag_asserts

bind sctag_top sctag_asserts chk_u (.clk(clk), .reset_n(reset_n), .access_sel_n(access_sel_n),
  .tag_store_n(tag_store_n), .flush_all_n(flush_all_n), .sel_low_a_n(sel_low_a_n), .sel_high_b(sel_high_b),
  .sel_low_c_n(sel_low_c_n), .drive_enable_n(drive_enable_n), .tagBusOe(tagBusOe),
  .entryLiveOut(entryLiveOut), .entryLiveOe(entryLiveOe), .tag_hit(tag_hit), .tagHitOe(tagHitOe));

/* verification/sctag_ctrl_model.sv */
// Controller-side model of the shared tag and valid lines
`timescale 1ns/100ps
module sctag_ctrl_model
  import sctag_pkg::*;
(
  input wire logic clk,
  input wire logic access_sel_n,
  input wire logic tag_store_n,
  input wire logic [SCTAG_TAG_W-1:0] ctlTag,
  input wire logic ctlLive,
  input wire logic [SCTAG_TAG_W-1:0] tagBusOut,
  input wire logic tagBusOe,
  input wire logic entryLiveOut,
  input wire logic entryLiveOe,
  output logic drive_enable_n,
  output logic [SCTAG_TAG_W-1:0] tagBusIn,
  output logic entryLiveIn
);
  logic [SCTAG_TAG_W-1:0] lastTag;
  logic lastLive;
  ////////////////////////////////////////
  // enable reads only
  assign drive_enable_n = access_sel_n || !tag_store_n;
  // Controller wins when it drives; a floating line shows the inverse of its last level
  assign tagBusIn = drive_enable_n ? ctlTag : tagBusOe ? tagBusOut : ~lastTag;
  assign entryLiveIn = drive_enable_n ? ctlLive : entryLiveOe ? entryLiveOut : ~lastLive;
  // Last wire levels
  always_ff @(posedge clk) begin
    lastTag <= tagBusIn;
    lastLive <= entryLiveIn;
  end
endmodule // sctag_ctrl_model

/* verification/tb_sync_cache_tag_compare_ram.sv */
// Self-checking bench for the cache tag compare memory
`timescale 1ns/100ps
module tb_sync_cache_tag_compare_ram
  import sctag_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [12:0] idx = 13'h0;
  logic accN = 1'b1;
  logic stN = 1'b1;
  logic flN = 1'b1;
  logic [2:0] cs = 3'h2;
  logic [14:0] tg = 15'h0;
  logic lv = 1'b0;
  logic oeN, tagBusOe, liveIn, entryLiveOut, entryLiveOe, tag_hit, tagHitOe;
  logic [14:0] tagBusIn, tagBusOut;
  logic [14:0] tagM [8192];
  bit valM [8192];
  logic [12:0] ix [8];
  logic [2:0] bad [3] = '{3'h6, 3'h0, 3'h3};
  logic [39:0] q [$];
  int fc = 0;
  int errors = 0;
  int total_checks = 0;
  int seed = 32'h0A5D;
  int r;
  ////////////////////////////////////////
  sctag_top dut_u (.clk(clk), .reset_n(reset_n), .entry_index(idx), .access_sel_n(accN), .tag_store_n(stN),
    .flush_all_n(flN), .sel_low_a_n(cs[2]), .sel_high_b(cs[1]), .sel_low_c_n(cs[0]), .drive_enable_n(oeN),
    .tagBusIn(tagBusIn), .tagBusOut(tagBusOut), .tagBusOe(tagBusOe), .entryLiveIn(liveIn),
    .entryLiveOut(entryLiveOut), .entryLiveOe(entryLiveOe), .tag_hit(tag_hit), .tagHitOe(tagHitOe));
  sctag_ctrl_model ctl_u (.clk(clk), .access_sel_n(accN), .tag_store_n(stN), .ctlTag(tg), .ctlLive(lv),
    .tagBusOut(tagBusOut), .tagBusOe(tagBusOe), .entryLiveOut(entryLiveOut), .entryLiveOe(entryLiveOe),
    .drive_enable_n(oeN), .tagBusIn(tagBusIn), .entryLiveIn(liveIn));
  // 50 MHz clock
  always #10 clk = ~clk;
  ////////////////////////////////////////
  // Masked compare, so unknowns only count where they matter
  task automatic chk(input string n, input logic [19:0] s, input logic [19:0] x);
    total_checks++;
    if (s !== x) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask
  // One operation per cycle; its result stands at the pins four operations later
  task automatic op(input logic [12:0] i, input logic a, s, f, input logic [2:0] c, input logic [14:0] t,
    input logic v);
    logic [19:0] e, m;
    @(posedge clk);
    #1;
    if (q.size() == 4) begin
      {e, m} = q.pop_front();
      chk("pins", {tag_hit, tagHitOe, entryLiveOut, entryLiveOe, tagBusOe, tagBusOut} & m, e & m);
    end
    idx = i; accN = a; stN = s; flN = f; cs = c; tg = t; lv = v;
    if (!f) begin
      e = 20'h40000;
      m = 20'hE0000;
    end else if (c != 3'h2) begin
      e = 20'h0;
      m = 20'h58000;
    end else if (a) begin
      e = {valM[i] && tagM[i] === t, 1'b1, valM[i], 17'h0};
      m = 20'hE8000;
    end else if (s) begin
      e = {2'b11, valM[i], 2'b00, tagM[i]};
      m = 20'hE7FFF;
    end else begin
      e = 20'hC0000;
      m = 20'hD8000;
      tagM[i] = t;
      valM[i] = v;
    end
    fc = f ? 0 : fc + 1;
    if (fc >= SCTAG_FLUSH_EDGES) valM = '{default: 1'b0};
    q.push_back({e, m});
  endtask
  // Verdict and end of run
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (4) op(0, 1, 1, 0, 2, 0, 0);
    for (int k = 0; k < 8; k++) begin
      r = $random(seed);
      ix[k] = k == 0 ? 13'h0 : k == 7 ? 13'h1FFF : r[12:0];
      op(ix[k], 0, 0, 1, 2, r[27:13], k != 3);
    end
    for (int k = 0; k < 8; k++) op(ix[k], 0, 1, 1, 2, 0, 0);
    for (int k = 0; k < 8; k++) op(ix[k], 1, 1, 1, 2, tagM[ix[k]] ^ (k == 5 ? 15'h4000 : 15'h0), 0);
    // Compare with store low must leave the entry alone
    op(ix[1], 1, 0, 1, 2, 15'h1234, 1);
    op(ix[1], 0, 1, 1, 2, 0, 0);
    // Three wrong select patterns each block a write
    foreach (bad[k]) begin
      op(ix[2], 0, 0, 1, bad[k], 15'h7FFF, 0);
      op(ix[2], 0, 1, 1, 2, 0, 0);
    end
    // Three flush edges fall short, four clear even when deselected
    repeat (3) op(0, 1, 1, 0, 2, 0, 0);
    op(ix[0], 1, 1, 1, 2, tagM[ix[0]], 0);
    repeat (4) op(0, 1, 1, 0, 0, 0, 0);
    op(ix[0], 1, 1, 1, 2, tagM[ix[0]], 0);
    // Random traffic with valid selects, except a random select pattern one op in eight
    repeat (300) begin
      r = $random(seed);
      op(ix[r[2:0]], r[3], r[4], |r[7:5], r[10:8] == 0 ? r[13:11] : 3'h2, r[28:14], r[29]);
    end
    repeat (6) op(0, 1, 1, 1, 2, 0, 0);
    final_report();
  end
endmodule // tb_sync_cache_tag_compare_ram
